// ### verilog/vprs_video_port_regs.sv
// port-mapped register set of an emulated colour video adapter
// assumes a host issuing one-cycle port read/write strobes on clk; blanking levels from pins
`timescale 1ns/100ps
`include "vprs_regs.svh"

// Summary of operation
// - index port write picks one of 256 colour table entries; reads do nothing
// - components 0 to 63 accepted; output truncated to 3/3/2 bits
// - data port reads return components of the indexed entry
// - data port writes update components of the indexed entry
// - controller data reads return the selected controller register
// - with index nine, data write sets scan lines per row, 0 to 7
// - two scan lines in 80-column text gives 160x100 sixteen-colour mode
// - mode bit 0 selects 80 columns in text mode, default one
// - mode bit 1 selects 320x200 four-colour graphics, default zero
// - mode bit 2 kills colour burst, with 640x200 gives 160x200 colour
// - mode bit 4 selects 640x200 monochrome, default zero, other bits ignored
// - in 320x200 four-colour, bit 4 intensifies, bit 5 picks alternate set
// - status bit 0 during any blanking, bit 3 during vertical blanking
// - status address write selects sixteen-colour entry, 10h to 1Fh
// - palette data write loads selected entry with colour 0 to 15
// - page register holds host and display page fields of three bits
// - in 320x200 sixteen-colour mode page field lsb is ignored
// - output bit 0 passes colour data; clear blanks colour, sync continues
// - output enable service acts only in 256-colour mode; 0 enables
module vprs_video_port_regs (
    input  wire logic              clk,
    input  wire logic              rst,
    input  vprs_pkg::vprs_io_t     io,
    output logic [7:0]             rdata,
    input  wire logic              hBlankPin,
    input  wire logic              vBlankPin,
    input  wire logic              mode256,
    input  wire logic              mode320x16,
    input  wire logic              outDisableReq,
    input  wire logic              outDisableVal,
    input  wire logic [7:0]        pixIndex,
    input  wire logic [3:0]        pixNibble,
    output vprs_pkg::vprs_rgb_t    pixRgb,
    output vprs_pkg::vprs_rgb_t    pixRgb16,
    output vprs_pkg::vprs_mode_t   modeOut
);
    import vprs_pkg::*;

    // colour table and sixteen-colour palette
    logic [17:0] colourTable [256];
    logic [3:0]  palette16   [16];

    logic [7:0]  ctIndex_q;
    vprs_comp_t  comp_q;
    logic [7:0]  dcIndex_q;
    logic [2:0]  scanLines_q;
    logic [7:0]  mode_q;
    logic [7:0]  csel_q;
    logic [3:0]  palSel_q;
    logic        palSelOk_q;
    logic [5:0]  page_q;
    logic        outEn_q;
    logic [2:0]  hSync_q;
    logic [2:0]  vSync_q;
    logic        hBlank_q;
    logic        vBlank_q;
    vprs_rgb_t   pixRgb_q;
    vprs_rgb_t   pixRgb16_q;

    function automatic vprs_rgb_t trunc332(input logic [17:0] e);
        trunc332 = '{red: e[17:15], green: e[11:9], blue: e[5:4]};
    endfunction : trunc332

    function automatic logic hit(input vprs_io_t b, input logic [15:0] a);
        hit = (b.addr == a);
    endfunction : hit

    // port decode
    wire wrCtIdx  = io.wr && hit(io, `VPRS_PORT_CT_INDEX);
    wire wrCtData = io.wr && hit(io, `VPRS_PORT_CT_DATA);
    wire rdCtData = io.rd && hit(io, `VPRS_PORT_CT_DATA);
    wire wrDcIdx  = io.wr && hit(io, `VPRS_PORT_DC_INDEX);
    wire wrDcData = io.wr && hit(io, `VPRS_PORT_DC_DATA);
    wire wrMode   = io.wr && hit(io, `VPRS_PORT_MODE);
    wire wrCsel   = io.wr && hit(io, `VPRS_PORT_CSEL);
    wire wrPalSel = io.wr && hit(io, `VPRS_PORT_STATUS);
    wire wrPalDat = io.wr && hit(io, `VPRS_PORT_PAL_DATA);
    wire wrPage   = io.wr && hit(io, `VPRS_PORT_PAGE);
    wire ctAccess = wrCtData || rdCtData;
    wire lastComp = (comp_q == VPRS_BLUE);

    // in-range palette selector
    wire palSelValid = (io.wdata >= `VPRS_PAL_SEL_BASE) && (io.wdata <= `VPRS_PAL_SEL_TOP);

    wire [17:0] ctEntry = colourTable[ctIndex_q];
    logic [5:0] ctComp;
    always_comb begin
        unique case (comp_q)
            VPRS_RED:   ctComp = ctEntry[17:12];
            VPRS_GREEN: ctComp = ctEntry[11:6];
            VPRS_BLUE:  ctComp = ctEntry[5:0];
            default:    ctComp = ctEntry[17:12];
        endcase
    end

    // red, green, blue, then back to red
    function automatic vprs_comp_t nextComp(input vprs_comp_t c);
        unique case (c)
            VPRS_RED:   nextComp = VPRS_GREEN;
            VPRS_GREEN: nextComp = VPRS_BLUE;
            VPRS_BLUE:  nextComp = VPRS_RED;
            default:    nextComp = VPRS_RED;
        endcase
    endfunction : nextComp

    // sequencer next state; the index wraps from the last entry to the first
    wire [7:0]  ctIndexInc = 8'(ctIndex_q + 8'h01);
    logic [7:0] ctIndex_d;
    vprs_comp_t comp_d;
    always_comb begin
        ctIndex_d = ctIndex_q;
        comp_d    = comp_q;
        if (wrCtIdx) begin
            ctIndex_d = io.wdata;
            comp_d    = VPRS_RED;
        end else if (ctAccess) begin
            comp_d = nextComp(comp_q);
            if (lastComp) begin
                ctIndex_d = ctIndexInc;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctIndex_q <= 8'h00;
            comp_q    <= VPRS_RED;
        end else begin
            ctIndex_q <= ctIndex_d;
            comp_q    <= comp_d;
        end
    end

    // component write, six bits kept per colour
    wire       ctWrRed   = wrCtData && (comp_q == VPRS_RED);
    wire       ctWrGreen = wrCtData && (comp_q == VPRS_GREEN);
    wire       ctWrBlue  = wrCtData && (comp_q == VPRS_BLUE);
    wire [5:0] ctWrComp  = io.wdata[5:0];

    always_ff @(posedge clk) begin
        if (ctWrRed) begin
            colourTable[ctIndex_q][17:12] <= ctWrComp;
        end
        if (ctWrGreen) begin
            colourTable[ctIndex_q][11:6] <= ctWrComp;
        end
        if (ctWrBlue) begin
            colourTable[ctIndex_q][5:0] <= ctWrComp;
        end
    end

    // controller index 9 is the only implemented register
    wire dcSelNine   = (dcIndex_q == `VPRS_DC_SCANLINE_IDX);
    wire wrScanLines = wrDcData && dcSelNine;

    always_ff @(posedge clk) begin
        if (rst) begin
            dcIndex_q <= `VPRS_DC_SCANLINE_IDX;
        end else if (wrDcIdx) begin
            dcIndex_q <= io.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            scanLines_q <= 3'h0;
        end else if (wrScanLines) begin
            scanLines_q <= io.wdata[2:0];
        end
    end

    // mode, colour-set and page registers are write-only
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= `VPRS_MODE_RESET;
        end else if (wrMode) begin
            mode_q <= io.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            csel_q <= 8'h00;
        end else if (wrCsel) begin
            csel_q <= io.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            page_q <= 6'h00;
        end else if (wrPage) begin
            page_q <= io.wdata[5:0];
        end
    end

    // an out-of-range selector blocks palette writes until the next select
    always_ff @(posedge clk) begin
        if (rst) begin
            palSel_q <= 4'h0;
        end else if (wrPalSel) begin
            palSel_q <= io.wdata[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            palSelOk_q <= 1'b0;
        end else if (wrPalSel) begin
            palSelOk_q <= palSelValid;
        end
    end

    always_ff @(posedge clk) begin
        if (wrPalDat && palSelOk_q) begin
            palette16[palSel_q] <= io.wdata[3:0];
        end
    end

    // output enable service, honoured only in 256-colour emulation
    always_ff @(posedge clk) begin
        if (rst) begin
            outEn_q <= `VPRS_OUTCTL_RESET;
        end else if (outDisableReq && mode256) begin
            outEn_q <= !outDisableVal;
        end
    end

    // blanking pins: three stages, change taken when stages two and three agree
    wire hAgree = (hSync_q[1] == hSync_q[2]);
    wire vAgree = (vSync_q[1] == vSync_q[2]);

    always_ff @(posedge clk) begin
        if (rst) begin
            hSync_q  <= 3'h0;
            hBlank_q <= 1'b0;
        end else begin
            hSync_q <= {hSync_q[1:0], hBlankPin};
            if (hAgree) begin
                hBlank_q <= hSync_q[2];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            vSync_q  <= 3'h0;
            vBlank_q <= 1'b0;
        end else begin
            vSync_q <= {vSync_q[1:0], vBlankPin};
            if (vAgree) begin
                vBlank_q <= vSync_q[2];
            end
        end
    end

    // read mux; no-function ports return a fixed value
    wire anyBlank = hBlank_q || vBlank_q;
    logic [7:0] statusByte;
    always_comb begin
        statusByte = 8'h00;
        statusByte[`VPRS_STAT_BLANK]  = anyBlank;
        statusByte[`VPRS_STAT_VBLANK] = vBlank_q;
    end

    wire [7:0] dcReadVal  = dcSelNine ? {5'h00, scanLines_q} : 8'h00;
    wire [7:0] ctReadVal  = {2'h0, ctComp};
    wire [7:0] outReadVal = {7'h00, outEn_q};
    wire       rdDcData   = io.rd && hit(io, `VPRS_PORT_DC_DATA);
    wire       rdStatus   = io.rd && hit(io, `VPRS_PORT_STATUS);
    wire       rdOutCtl   = io.rd && hit(io, `VPRS_PORT_OUTCTL);

    // reads of write-only or unmapped ports touch no state
    assign rdata = rdCtData ? ctReadVal :
                   rdDcData ? dcReadVal :
                   rdStatus ? statusByte :
                   rdOutCtl ? outReadVal : `VPRS_NOFUNC_READ;

    // pixel outputs registered; colour forced off while output disabled
    wire [17:0] pixEntry  = colourTable[pixIndex];
    wire [3:0]  pixColour = palette16[pixNibble];
    vprs_rgb_t  pixTrunc;
    vprs_rgb_t  pixPal;
    assign pixTrunc = outEn_q ? trunc332(pixEntry) : '0;
    assign pixPal   = outEn_q ? vprs_rgb_t'({4'h0, pixColour}) : '0;

    always_ff @(posedge clk) begin
        if (rst) begin
            pixRgb_q <= '0;
        end else begin
            pixRgb_q <= pixTrunc;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pixRgb16_q <= '0;
        end else begin
            pixRgb16_q <= pixPal;
        end
    end

    assign pixRgb   = pixRgb_q;
    assign pixRgb16 = pixRgb16_q;

    // mode decode
    wire       modeCol80   = mode_q[`VPRS_MODE_COL80];
    wire       modeGfx320  = mode_q[`VPRS_MODE_GFX320];
    wire       modeNoBurst = mode_q[`VPRS_MODE_NOBURST];
    wire       modeHiRes   = mode_q[`VPRS_MODE_HIRES];
    // text means neither graphics bit; colour-set bits act only in four-colour
    wire       textMode    = !modeGfx320 && !modeHiRes;
    wire       fourCol     = modeGfx320 && !modeHiRes;
    wire       col80Active = modeCol80 && textMode;
    wire       tweakActive = col80Active && (scanLines_q == `VPRS_TWEAK_LINES);
    wire       compActive  = modeHiRes && modeNoBurst;
    wire [2:0] pageMask    = mode320x16 ? 3'h6 : 3'h7;
    wire [2:0] hostPage    = page_q[2:0] & pageMask;
    wire [2:0] dispPage    = page_q[5:3] & pageMask;

    always_comb begin
        modeOut.col80            = col80Active;
        modeOut.gfx320           = modeGfx320;
        modeOut.noBurst          = modeNoBurst;
        modeOut.hiRes            = modeHiRes;
        modeOut.tweak160x100     = tweakActive;
        modeOut.comp160x200      = compActive;
        modeOut.intense          = fourCol && csel_q[`VPRS_CSEL_INTENSE];
        modeOut.altSet           = fourCol && csel_q[`VPRS_CSEL_ALTSET];
        modeOut.hostPageField    = hostPage;
        modeOut.displayPageField = dispPage;
        modeOut.pixelEnable      = outEn_q;
    end
endmodule : vprs_video_port_regs

// ### common/vprs_regs.svh
// port addresses, field positions and reset values of the video port register set
// assumes a 16-bit port address space with byte-wide data
`ifndef VPRS_REGS_SVH
`define VPRS_REGS_SVH
`define VPRS_PORT_CT_INDEX   16'h03C8
`define VPRS_PORT_CT_DATA    16'h03C9
`define VPRS_PORT_DC_INDEX   16'h03D4
`define VPRS_PORT_DC_DATA    16'h03D5
`define VPRS_PORT_MODE       16'h03D8
`define VPRS_PORT_CSEL       16'h03D9
`define VPRS_PORT_STATUS     16'h03DA
`define VPRS_PORT_PAL_DATA   16'h03DE
`define VPRS_PORT_PAGE       16'h03DF
`define VPRS_PORT_OUTCTL     16'h1010
`define VPRS_DC_SCANLINE_IDX 8'h09
`define VPRS_TWEAK_LINES     3'h2
`define VPRS_MODE_RESET      8'h05
`define VPRS_PAL_SEL_BASE    8'h10
`define VPRS_PAL_SEL_TOP     8'h1F
`define VPRS_OUTCTL_RESET    1'h1
`define VPRS_NOFUNC_READ     8'hFF
`define VPRS_COMP_LAST       2'h2
`define VPRS_MODE_COL80      0
`define VPRS_MODE_GFX320     1
`define VPRS_MODE_NOBURST    2
`define VPRS_MODE_HIRES      4
`define VPRS_CSEL_INTENSE    4
`define VPRS_CSEL_ALTSET     5
`define VPRS_STAT_BLANK      0
`define VPRS_STAT_VBLANK     3
`endif

// ### common/vprs_pkg.sv
// types shared by the video port register set
// assumes the constants in vprs_regs.svh
package vprs_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } vprs_io_t;

    typedef struct packed {
        logic [2:0] red;
        logic [2:0] green;
        logic [1:0] blue;
    } vprs_rgb_t;

    typedef struct packed {
        logic       col80;
        logic       gfx320;
        logic       noBurst;
        logic       hiRes;
        logic       tweak160x100;
        logic       comp160x200;
        logic       intense;
        logic       altSet;
        logic [2:0] hostPageField;
        logic [2:0] displayPageField;
        logic       pixelEnable;
    } vprs_mode_t;

    typedef enum logic [2:0] {
        VPRS_RED   = 3'b001,
        VPRS_GREEN = 3'b010,
        VPRS_BLUE  = 3'b100
    } vprs_comp_t;
endpackage : vprs_pkg

// ### dv/vprs_video_port_regs_assertions.sv
// concurrent checks on the ports of the video port register set
// assumes port macros from vprs_regs.svh and a single clk domain
`timescale 1ns/100ps
`include "vprs_regs.svh"
module vprs_video_port_regs_assertions (
    input wire logic            clk,
    input wire logic            rst,
    input vprs_pkg::vprs_io_t   io,
    input wire logic [7:0]      rdata,
    input wire logic            hBlankPin,
    input wire logic            vBlankPin,
    input wire logic            mode256,
    input wire logic            mode320x16,
    input wire logic            outDisableReq,
    input wire logic            outDisableVal,
    input wire logic [7:0]      pixIndex,
    input wire logic [3:0]      pixNibble,
    input vprs_pkg::vprs_rgb_t  pixRgb,
    input vprs_pkg::vprs_rgb_t  pixRgb16,
    input vprs_pkg::vprs_mode_t modeOut
);
    import vprs_pkg::*;
    wire wrMode = io.wr && io.addr == `VPRS_PORT_MODE;
    wire wrCsel = io.wr && io.addr == `VPRS_PORT_CSEL;
    wire wrPage = io.wr && io.addr == `VPRS_PORT_PAGE;
    wire rdStat = io.rd && io.addr == `VPRS_PORT_STATUS;
    wire rdNone = io.rd && io.addr == `VPRS_PORT_CT_INDEX;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_noop_read: assert property (rdNone |-> rdata == `VPRS_NOFUNC_READ)
        else $error("index port read not fixed");
    a_any_blank: assert property ((hBlankPin || vBlankPin) [*5] ##0 rdStat |-> rdata[0])
        else $error("blank bit missing");
    a_vblank_only: assert property (!vBlankPin [*5] ##0 rdStat |-> !rdata[3])
        else $error("vertical bit without vertical blank");
    a_mode_reset: assert property ($fell(rst) |-> modeOut.col80 && modeOut.noBurst
        && !modeOut.gfx320 && !modeOut.hiRes) else $error("mode reset value");
    a_mode_bits: assert property (wrMode |=> modeOut.gfx320 == $past(io.wdata[1])
        && modeOut.noBurst == $past(io.wdata[2]) && modeOut.hiRes == $past(io.wdata[4]))
        else $error("mode bits");
    a_comp_mode: assert property (wrMode |=> modeOut.comp160x200
        == ($past(io.wdata[4]) && $past(io.wdata[2]))) else $error("composite mode decode");
    a_csel_bits: assert property (wrCsel ##1 (modeOut.gfx320 && !modeOut.hiRes)
        |-> modeOut.intense == $past(io.wdata[4]) && modeOut.altSet == $past(io.wdata[5]))
        else $error("colour set bits");
    a_page_fields: assert property (wrPage ##1 !mode320x16
        |-> modeOut.hostPageField == $past(io.wdata[2:0])
        && modeOut.displayPageField == $past(io.wdata[5:3])) else $error("page fields");
    a_page_pairs: assert property (mode320x16 |-> !modeOut.hostPageField[0]
        && !modeOut.displayPageField[0]) else $error("page lsb not ignored");
    a_out_request: assert property (outDisableReq && mode256
        |=> modeOut.pixelEnable == !$past(outDisableVal)) else $error("output request");
    a_out_ignored: assert property (outDisableReq && !mode256
        |=> $stable(modeOut.pixelEnable)) else $error("output request outside mode");
    a_blank_pixels: assert property (!modeOut.pixelEnable [*2]
        |-> pixRgb == 8'h00 && pixRgb16 == 8'h00) else $error("colour not switched off");
    c_mode_write: cover property (wrMode);
    c_vblank_read: cover property (rdStat && rdata[3]);
    c_out_off: cover property (outDisableReq && mode256 && outDisableVal);
endmodule : vprs_video_port_regs_assertions

bind vprs_video_port_regs vprs_video_port_regs_assertions i_chk (
    .clk(clk), .rst(rst), .io(io), .rdata(rdata), .hBlankPin(hBlankPin),
    .vBlankPin(vBlankPin), .mode256(mode256), .mode320x16(mode320x16),
    .outDisableReq(outDisableReq), .outDisableVal(outDisableVal), .pixIndex(pixIndex),
    .pixNibble(pixNibble), .pixRgb(pixRgb), .pixRgb16(pixRgb16), .modeOut(modeOut));

// ### dv/vprs_host_model.sv
// host processor model issuing port reads and writes
// assumes strobes are taken on the rising edge of clk
`timescale 1ns/100ps
module vprs_host_model (
    output vprs_pkg::vprs_io_t io,
    input  wire logic          clk,
    input  wire logic [7:0]    rdata
);
    import vprs_pkg::*;
    initial io = '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, wdata: 8'h00};
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk);
        io = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        @(negedge clk);
        io.wr = 1'b0;
        io.wdata = ~v;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(negedge clk);
        io = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: io.wdata};
        @(posedge clk);
        v = rdata;
        @(negedge clk);
        io.rd = 1'b0;
    endtask : rd
    task automatic ent(input logic [7:0] r, g, b);
        wr(16'h03C9, r);
        wr(16'h03C9, g);
        wr(16'h03C9, b);
    endtask : ent
endmodule : vprs_host_model

// ### dv/video_port_register_set_tb.sv
// self-checking bench of the video port register set
// assumes the host model drives io; bench drives pins at the falling edge
`timescale 1ns/100ps
module video_port_register_set_tb;
    import vprs_pkg::*;
    logic       clk = 0;
    logic       rst = 1;
    logic       hB = 0, vB = 0, m256 = 0, m3216 = 0, oReq = 0, oVal = 0;
    logic [7:0] pixIndex = 0, d;
    logic [3:0] pixNibble = 0;
    vprs_io_t   io;
    vprs_rgb_t  pixRgb, pixRgb16;
    vprs_mode_t mo;
    int         bad_count = 0, n_checks = 0;
    logic [7:0] d8;
    always #2.5 clk = ~clk;
    vprs_host_model i_host (.io(io), .clk(clk), .rdata(d8));
    vprs_video_port_regs i_dut (.clk(clk), .rst(rst), .io(io), .rdata(d8),
        .hBlankPin(hB), .vBlankPin(vB), .mode256(m256), .mode320x16(m3216),
        .outDisableReq(oReq), .outDisableVal(oVal), .pixIndex(pixIndex),
        .pixNibble(pixNibble), .pixRgb(pixRgb), .pixRgb16(pixRgb16), .modeOut(mo));
    task automatic chk(input logic [15:0] g, e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    task automatic t_reset;
        chk(16'({mo.col80, mo.gfx320, mo.noBurst, mo.hiRes}), 16'hA);
        chk(16'({mo.displayPageField, mo.hostPageField}), 16'h0);
        i_host.rd(16'h1010, d);
        chk(16'(d[0]), 16'h1);
        i_host.rd(16'h03C8, d);
        chk(16'(d), 16'hFF);
        i_host.rd(16'h03D0, d);
        chk(16'(d), 16'hFF);
    endtask : t_reset
    task automatic t_colour;
        logic [7:0] ex[6] = '{8'h3F, 8'h00, 8'h2A, 8'h01, 8'h20, 8'h15};
        i_host.wr(16'h03C9, 8'h11);
        i_host.wr(16'h03C8, 8'hFF);
        i_host.ent(8'h3F, 8'h00, 8'h2A);
        i_host.rd(16'h03DE, d);
        i_host.ent(8'h01, 8'h20, 8'h15);
        i_host.wr(16'h03C8, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            i_host.rd(16'h03C9, d);
            chk(16'(d[5:0]), 16'(ex[i]));
        end
        @(negedge clk) pixIndex = 8'hFF;
        repeat (3) @(negedge clk);
        chk(16'(pixRgb), 16'h00E2);
        pixIndex = 8'h00;
        repeat (3) @(negedge clk);
        chk(16'(pixRgb), 16'h0011);
    endtask : t_colour
    task automatic t_dc;
        i_host.wr(16'h03D4, 8'h09);
        i_host.wr(16'h03D5, 8'h02);
        i_host.rd(16'h03D5, d);
        chk(16'(d), 16'h0002);
        chk(16'(mo.tweak160x100), 16'h1);
        i_host.wr(16'h03D5, 8'h07);
        i_host.rd(16'h03D5, d);
        chk(16'(d), 16'h0007);
        chk(16'(mo.tweak160x100), 16'h0);
    endtask : t_dc
    task automatic t_mode;
        logic [7:0] w[4] = '{8'h10, 8'h14, 8'hEA, 8'h05};
        logic [4:0] e[4] = '{5'b00010, 5'b00111, 5'b01000, 5'b10100};
        for (int i = 0; i < 4; i++) begin
            i_host.wr(16'h03D8, w[i]);
            chk(16'({mo.col80, mo.gfx320, mo.noBurst, mo.hiRes, mo.comp160x200}), 16'(e[i]));
        end
        i_host.wr(16'h03D8, 8'h02);
        i_host.wr(16'h03D9, 8'h30);
        chk(16'({mo.intense, mo.altSet}), 16'h3);
        i_host.wr(16'h03D8, 8'h12);
        chk(16'({mo.intense, mo.altSet}), 16'h0);
        i_host.wr(16'h03D8, 8'h02);
        i_host.wr(16'h03D9, 8'hCF);
        chk(16'({mo.intense, mo.altSet}), 16'h0);
        i_host.wr(16'h03DF, 8'hEB);
        chk(16'({mo.displayPageField, mo.hostPageField}), 16'h2B);
        @(negedge clk) m3216 = 1;
        #1 chk(16'({mo.displayPageField, mo.hostPageField}), 16'h22);
        @(negedge clk) m3216 = 0;
        i_host.wr(16'h03D8, 8'h05);
    endtask : t_mode
    task automatic t_stat(input logic h, v, input logic [7:0] e);
        @(negedge clk) {hB, vB} = {h, v};
        repeat (6) @(negedge clk);
        i_host.rd(16'h03DA, d);
        chk(16'(d & 8'h09), 16'(e));
    endtask : t_stat
    task automatic t_pal;
        i_host.wr(16'h03DA, 8'h13);
        i_host.wr(16'h03DE, 8'h09);
        // out of range, but its low nibble aims at entry 3 so a leak would show
        i_host.wr(16'h03DA, 8'h03);
        i_host.wr(16'h03DE, 8'h02);
        i_host.wr(16'h03DA, 8'h1F);
        i_host.wr(16'h03DE, 8'h0F);
        @(negedge clk) pixNibble = 4'h3;
        repeat (3) @(negedge clk);
        chk(16'(pixRgb16[3:0]), 16'h9);
        pixNibble = 4'hF;
        repeat (3) @(negedge clk);
        chk(16'(pixRgb16[3:0]), 16'hF);
    endtask : t_pal
    task automatic pulse(input logic m, v);
        @(negedge clk) {m256, oReq, oVal} = {m, 1'b1, v};
        @(negedge clk) oReq = 0;
        repeat (2) @(negedge clk);
    endtask : pulse
    task automatic t_out;
        pulse(1'b0, 1'b1);
        chk(16'(mo.pixelEnable), 16'h1);
        pulse(1'b1, 1'b1);
        i_host.rd(16'h1010, d);
        chk(16'(d[0]), 16'h0);
        chk(16'(pixRgb), 16'h0);
        chk(16'(pixRgb16), 16'h0);
        pulse(1'b1, 1'b0);
        chk(16'(mo.pixelEnable), 16'h1);
    endtask : t_out
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk) rst = 0;
        t_reset();
        t_colour();
        t_dc();
        t_mode();
        t_stat(1'b1, 1'b0, 8'h01);
        t_stat(1'b0, 1'b1, 8'h09);
        t_stat(1'b0, 1'b0, 8'h00);
        t_pal();
        t_out();
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule : video_port_register_set_tb
